// file: bench/debug_host_model.sv
// behavioural debug host on the background debug link
// assumes the bench calls its tasks from one thread, one request at a time
`timescale 1ns/1ps
module debug_host_model
   import flash_security_pkg::*;
(
   // clock
   input wire logic pclk,
   // debug link requests
   output logic dbg_cmd_valid,
   output flash_security_pkg::dbg_class_e dbg_cmd_class,
   output logic dbg_go
);
   initial begin
      dbg_cmd_valid = 1'b0;
      dbg_cmd_class = dbg_other;
      dbg_go = 1'b0;
   end
   ////////////////////////////////////////////////////////////////
   task automatic send(input dbg_class_e c);
      @(posedge pclk);
      dbg_cmd_valid <= 1'b1;
      dbg_cmd_class <= c;
   endtask : send
   // idle class is scrambled so a stale class never passes for a request
   task automatic quiet();
      @(posedge pclk);
      dbg_cmd_valid <= 1'b0;
      dbg_cmd_class <= dbg_class_e'(~dbg_cmd_class);
      dbg_go <= 1'b0;
   endtask : quiet
   task automatic go();
      @(posedge pclk);
      dbg_go <= 1'b1;
   endtask : go
endmodule : debug_host_model

// file: bench/flash_security_control_test.sv
// self-checking bench for flash_security_control against an integer model
// waits on pready for every access; expects a running block from the 6th edge after reset
`timescale 1ns/1ps
module flash_security_control_test;
   import flash_security_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, chip_mode_select, opt_sector_protected;
   logic [7:0] paddr, nvm_opt_byte, nvm_cmd_code, opt_prog_data;
   logic [31:0] pwdata, prdata, rd;
   logic [63:0] nvm_key;
   logic nvm_cmd_valid, nvm_cmd_allow, nvm_erase_all_done, nvm_erase_all_ok, opt_prog_req, err;
   logic [23:0] nvm_cmd_addr, nvm_erase_base;
   logic dbg_cmd_valid, dbg_go, dbg_enable, dbg_cmd_accept, dbg_cmd_reject, dbg_mem_block;
   logic active_debug_state, secured, normal_run_chip_mode;
   logic [7:0] codes [4] = '{cmd_erase_verify_all, cmd_program, cmd_erase_all, cmd_erase_sector};
   logic [15:0] kw [4];
   dbg_class_e dbg_cmd_class;
   int bad_count, n_tests, cycles, m_sec, m_norm, m_bd;

   flash_security_control flash_security_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .chip_mode_select(chip_mode_select), .nvm_opt_byte(nvm_opt_byte), .nvm_key(nvm_key),
      .opt_sector_protected(opt_sector_protected), .nvm_cmd_valid(nvm_cmd_valid), .nvm_cmd_code(nvm_cmd_code),
      .nvm_cmd_addr(nvm_cmd_addr), .nvm_cmd_allow(nvm_cmd_allow), .nvm_erase_base(nvm_erase_base),
      .nvm_erase_all_done(nvm_erase_all_done), .nvm_erase_all_ok(nvm_erase_all_ok), .opt_prog_req(opt_prog_req),
      .opt_prog_data(opt_prog_data), .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd_class(dbg_cmd_class),
      .dbg_go(dbg_go), .dbg_enable(dbg_enable), .dbg_cmd_accept(dbg_cmd_accept), .dbg_cmd_reject(dbg_cmd_reject),
      .dbg_mem_block(dbg_mem_block), .active_debug_state(active_debug_state), .secured(secured),
      .normal_run_chip_mode(normal_run_chip_mode));
   debug_host_model host_i (.pclk(pclk), .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd_class(dbg_cmd_class),
      .dbg_go(dbg_go));
   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // the whole run needs well under 2000 cycles
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         bad_count++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic exp_sec();
      return !(m_sec == 2 || m_bd == 1);
   endfunction : exp_sec
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic look();
      @(posedge pclk);
      #1;
   endtask : look
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // this wait ends once pready is seen high, or else at the bench timeout
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      check("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic boot(input logic [7:0] opt, input logic mode);
      @(posedge pclk);
      presetn <= 1'b0;
      nvm_opt_byte <= opt;
      chip_mode_select <= mode;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      #1;
      m_sec = opt[1:0];
      m_norm = mode;
      m_bd = 0;
   endtask : boot
   task automatic close_out();
      $display("counts: %0d checks, %0d mismatches", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////
   initial begin
      {presetn, psel, penable, pwrite, opt_sector_protected, nvm_cmd_valid} = '0;
      {nvm_erase_all_done, nvm_erase_all_ok, paddr, pwdata, nvm_cmd_code, nvm_cmd_addr} = '0;
      chip_mode_select = 1'b1;
      nvm_opt_byte = 8'hff;
      nvm_key = 64'h1234_5678_9abc_def0;
      void'($urandom(43073));
      for (int md = 0; md < 2; md++) begin
         for (int s = 0; s < 4; s++) begin
            boot({keyen_enabled, 4'($urandom), 2'(s)}, md[0]);
            apb(reg_copy_off, 1'b0, 32'h0);
            check("copy", rd, {24'h0, nvm_opt_byte});
            check("secured", secured, exp_sec());
            check("mode", normal_run_chip_mode, m_norm);
            check("dbg_en", dbg_enable, !(exp_sec() && m_norm));
            check("active_dbg", active_debug_state, !m_norm);
            for (int c = 0; c < 4; c++) begin
               host_i.send(dbg_class_e'(c));
               nvm_cmd_valid <= 1'b1;
               nvm_cmd_code <= codes[c];
               nvm_cmd_addr <= 24'($urandom % 32'h7ffe00);
               look();
               check("dbg_accept", dbg_cmd_accept, !exp_sec() || (!m_norm && c < 2));
               check("dbg_reject", dbg_cmd_reject, exp_sec() && (m_norm || c > 1));
               check("mem_block", dbg_mem_block, exp_sec() && !m_norm);
               check("nvm_allow", nvm_cmd_allow, !exp_sec() || c == 0 || c == 2);
            end
            host_i.quiet();
            nvm_cmd_valid <= 1'b0;
            host_i.go();
            host_i.quiet();
            look();
            check("active_dbg_go", active_debug_state, 1'b0);
            $display("test mode %0d security %0d done", md, s);
         end
      end
      // protected options sector refuses both program and erase
      boot({keyen_enabled, 4'hf, sec_unsecured}, 1'b1);
      for (int p = 1; p >= 0; p--) begin
         for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            opt_sector_protected <= p[0];
            nvm_cmd_valid <= 1'b1;
            nvm_cmd_code <= k ? cmd_erase_sector : cmd_program;
            nvm_cmd_addr <= opt_sector_base + 24'($urandom % 512);
            look();
            check("opt_allow", nvm_cmd_allow, p == 0);
         end
      end
      look();
      check("erase_base", nvm_erase_base, opt_sector_base);
      nvm_cmd_valid <= 1'b0;
      // new security bits only take hold through a reset
      nvm_opt_byte <= {keyen_enabled, 4'h0, sec_unsecured};
      boot({keyen_enabled, 4'h0, sec_recommended}, 1'b1);
      nvm_opt_byte <= {keyen_enabled, 4'h0, sec_unsecured};
      repeat (3) look();
      check("sec_hold", secured, 1'b1);
      boot({keyen_enabled, 4'h0, sec_unsecured}, 1'b1);
      check("sec_reload", secured, 1'b0);
      $display("test sector and reprogram done");
      for (int bad = 0; bad < 2; bad++) begin
         for (int i = 0; i < 4; i++) begin
            kw[i] = 16'h1 + 16'($urandom % 32'hfffd);
            if (bad == 1 && i == 2) kw[i] = key_invalid_hi;
            nvm_key[16*i +: 16] <= kw[i];
         end
         boot({keyen_enabled, 4'h0, sec_recommended}, 1'b1);
         apb(reg_key_ctrl_off, 1'b1, 32'h1);
         for (int i = 0; i < 4; i++) apb(reg_key_base_off + 8'(4 * i), 1'b1, {16'h0, kw[i]});
         apb(reg_key_ctrl_off, 1'b1, 32'h3);
         look();
         look();
         m_bd = (bad == 0);
         check("backdoor", secured, exp_sec());
         apb(reg_status_off, 1'b0, 32'h0);
         check("st_backdoor", rd[st_backdoor_bit], m_bd);
         boot({keyen_enabled, 4'h0, sec_recommended}, 1'b1);
         check("bd_reset", secured, 1'b1);
      end
      $display("test back door done");
      boot({keyen_enabled, 4'h0, sec_recommended}, 1'b0);
      @(posedge pclk);
      nvm_erase_all_done <= 1'b1;
      nvm_erase_all_ok <= 1'b1;
      @(posedge pclk);
      nvm_erase_all_done <= 1'b0;
      #1;
      check("prog_req", opt_prog_req, 1'b1);
      check("prog_data", opt_prog_data, opt_byte_unsecured);
      m_bd = 1;
      look();
      check("prog_req_end", opt_prog_req, 1'b0);
      check("erase_unsec", secured, exp_sec());
      apb(8'h0c, 1'b0, 32'h0);
      check("unmapped_err", err, 1'b1);
      check("unmapped_data", rd, 32'h0);
      $display("test full erase done");
      close_out();
   end
endmodule : flash_security_control_test

// file: hw/backdoor_key_check.sv
// back door key words written by software, compared with the stored key
// assumes the stored key is stable after reset; words clear only on reset
`timescale 1ns/1ps
module backdoor_key_check #(
   parameter int words = 4,
   parameter int width = 16
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write side
   input wire logic wr_en,
   input wire logic [1:0] wr_idx,
   input wire logic [width-1:0] wr_data,
   // stored key and results
   input wire logic [words*width-1:0] stored_key,
   output logic all_written,
   output logic keys_valid,
   output logic keys_match
);
   import flash_security_pkg::*;

   logic [words-1:0] written_w;
   logic [words-1:0] valid_w;
   logic [words-1:0] match_w;

   genvar g;
   generate
      for (g = 0; g < words; g++) begin : gen_word
         logic [width-1:0] word_reg;
         logic [width-1:0] stored_w;
         // one flag per word, so each process owns its own variable
         logic word_written_reg;
         assign stored_w = stored_key[g*width +: width];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               word_reg <= '0;
               word_written_reg <= 1'b0;
            end else if (wr_en && wr_idx == 2'(g)) begin
               word_reg <= wr_data;
               word_written_reg <= 1'b1;
            end
         end
         assign written_w[g] = word_written_reg;
         // all-zero and all-one words never count as a key
         assign valid_w[g] = stored_w != key_invalid_lo && stored_w != key_invalid_hi; // R10
         assign match_w[g] = word_written_reg && word_reg == stored_w;
      end
   endgenerate

   assign all_written = &written_w;
   assign keys_valid = &valid_w; // R10
   assign keys_match = &match_w;
endmodule : backdoor_key_check

// file: hw/flash_security_control.sv
// flash security control: security decode, debug and nvm command gating
// assumes the options byte and stored key are readable from reset onward
// and that the mode pin is asynchronous to pclk
//
// Overview of operation
// (R01) each reset copies the options/security byte; security follows that copy
// (R02) only security bits 10 unsecure; 00, 01 and 11 all secure
// (R03) software should write 01 to secure the device
// (R04) secured in normal run mode: debug controller fully disabled
// (R05) secured in any mode: only permitted flash/eeprom commands run
// (R06) special debug mode: enter active debug state right after reset
// (R07) secured special mode: debug accepts only mass erase and its status register
// (R08) secured special mode: debug memory accesses are blocked
// (R09) normal mode back door: valid key, keys enabled, matching key writes unsecure
// (R10) key words 0x0000 or 0xffff are invalid and never unsecure
// (R11) options byte program/erase only when its sector is unprotected
// (R12) erasing the options byte clears its whole sector
// (R13) reprogrammed security bits take effect only at the next reset
// (R14) successful full erase unsecures and programs the unsecured byte
// (R15) chip mode captured from mode pin at reset release; 1 normal, 0 special
// (R16) back door unsecure lasts only until the next reset
`timescale 1ns/1ps
module flash_security_control #(
   parameter int words = flash_security_pkg::key_words,
   parameter int width = flash_security_pkg::key_width
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mode pin and nonvolatile contents
   input wire logic chip_mode_select,
   input wire logic [7:0] nvm_opt_byte,
   input wire logic [words*width-1:0] nvm_key,
   input wire logic opt_sector_protected,
   // nvm command filter
   input wire logic nvm_cmd_valid,
   input wire logic [7:0] nvm_cmd_code,
   input wire logic [23:0] nvm_cmd_addr,
   output logic nvm_cmd_allow,
   output logic [23:0] nvm_erase_base,
   input wire logic nvm_erase_all_done,
   input wire logic nvm_erase_all_ok,
   output logic opt_prog_req,
   output logic [7:0] opt_prog_data,
   // background debug controller
   input wire logic dbg_cmd_valid,
   input wire flash_security_pkg::dbg_class_e dbg_cmd_class,
   input wire logic dbg_go,
   output logic dbg_enable,
   output logic dbg_cmd_accept,
   output logic dbg_cmd_reject,
   output logic dbg_mem_block,
   output logic active_debug_state,
   // status
   output logic secured,
   output logic normal_run_chip_mode
);
   import flash_security_pkg::*;

   typedef enum {st_sync, st_load, st_run} phase_e;

   phase_e phase_reg;
   logic [1:0] wait_reg;
   logic chip_mode_select_meta_reg;
   logic chip_mode_select_sync_reg;
   logic [7:0] flash_security_copy;
   logic normal_reg;
   logic active_dbg_reg;
   logic backdoor_reg;
   logic erase_unsec_reg;
   logic [1:0] key_ctrl_reg;
   logic [31:0] prdata_reg;
   logic [23:0] erase_base_reg;
   logic opt_prog_reg;
   logic apb_wr;
   logic apb_setup;
   logic key_wr;
   logic verify_wr;
   logic mapped;
   logic in_run;
   logic keys_written;
   logic keys_valid;
   logic keys_match;
   logic [1:0] security_state_bits;
   logic [1:0] backdoor_key_enable_bits;
   logic opt_sector_hit;
   logic cmd_permitted;
   logic [31:0] status_w;

   ////////////////////////////////////////////////////////////////////////
   // mode pin synchroniser and reset-release sequence

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_mode_select_meta_reg <= 1'b1;
         chip_mode_select_sync_reg <= 1'b1;
      end else begin
         chip_mode_select_meta_reg <= chip_mode_select;
         chip_mode_select_sync_reg <= chip_mode_select_meta_reg;
      end
   end

   // hold the load until the pin has crossed both flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= st_sync;
         wait_reg <= '0;
      end else begin
         unique case (phase_reg)
            st_sync: begin
               wait_reg <= wait_reg + 2'h1;
               if (wait_reg == sync_wait - 2'h1) begin
                  phase_reg <= st_load;
               end
            end
            st_load: phase_reg <= st_run;
            st_run: phase_reg <= st_run;
         endcase
      end
   end

   assign in_run = phase_reg == st_run;

   // the copy is only written in the load phase, so reprogramming waits for reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_security_copy <= reg_copy_rst;
         normal_reg <= 1'b1;
      end else if (phase_reg == st_load) begin
         flash_security_copy <= nvm_opt_byte; // R01 R13
         normal_reg <= chip_mode_select_sync_reg; // R15
      end
   end

   assign security_state_bits = flash_security_copy[sec_lsb +: 2];
   assign backdoor_key_enable_bits = flash_security_copy[keyen_lsb +: 2];
   // held secured until the copy is loaded; 01 is only what software should write
   assign secured = !(in_run && (security_state_bits == sec_unsecured || backdoor_reg || erase_unsec_reg)); // R02 R03
   assign normal_run_chip_mode = normal_reg;

   ////////////////////////////////////////////////////////////////////////
   // background debug gating

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_dbg_reg <= 1'b0;
      end else if (phase_reg == st_load && !chip_mode_select_sync_reg) begin
         active_dbg_reg <= 1'b1; // R06
      end else if (dbg_go) begin
         active_dbg_reg <= 1'b0;
      end
   end

   assign active_debug_state = active_dbg_reg;
   assign dbg_enable = in_run && !(secured && normal_reg); // R04
   assign dbg_mem_block = secured && !normal_reg; // R08
   always_comb begin
      dbg_cmd_accept = 1'b0;
      if (dbg_cmd_valid && dbg_enable) begin
         if (!secured) begin
            dbg_cmd_accept = 1'b1;
         end else begin
            dbg_cmd_accept = dbg_cmd_class == dbg_mass_erase || dbg_cmd_class == dbg_csr; // R07
         end
      end
   end
   assign dbg_cmd_reject = dbg_cmd_valid && !dbg_cmd_accept; // R07 R04

   ////////////////////////////////////////////////////////////////////////
   // nvm command filter

   assign opt_sector_hit = (nvm_cmd_addr & ~opt_sector_mask) == opt_sector_base;
   assign cmd_permitted = nvm_cmd_code == cmd_erase_verify_all || nvm_cmd_code == cmd_erase_all;
   always_comb begin
      nvm_cmd_allow = nvm_cmd_valid && in_run;
      if (secured && !cmd_permitted) begin
         nvm_cmd_allow = 1'b0; // R05
      end
      if (opt_sector_hit && opt_sector_protected &&
          (nvm_cmd_code == cmd_program || nvm_cmd_code == cmd_erase_sector)) begin
         nvm_cmd_allow = 1'b0; // R11
      end
   end

   // sector erase always spans the full aligned sector, key and vectors included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_base_reg <= '0;
      end else if (nvm_cmd_allow && nvm_cmd_code == cmd_erase_sector) begin
         erase_base_reg <= nvm_cmd_addr & ~opt_sector_mask; // R12
      end
   end
   assign nvm_erase_base = erase_base_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_unsec_reg <= 1'b0;
         opt_prog_reg <= 1'b0;
      end else begin
         opt_prog_reg <= nvm_erase_all_done && nvm_erase_all_ok; // R14
         if (nvm_erase_all_done && nvm_erase_all_ok) begin
            erase_unsec_reg <= 1'b1; // R14
         end
      end
   end
   assign opt_prog_req = opt_prog_reg;
   assign opt_prog_data = opt_byte_unsecured;

   ////////////////////////////////////////////////////////////////////////
   // back door key access

   assign apb_wr = psel && penable && pwrite;
   assign apb_setup = psel && !penable;
   assign key_wr = apb_wr && key_ctrl_reg[kc_access_bit] && paddr[7:4] == reg_key_base_off[7:4];
   assign verify_wr = apb_wr && paddr == reg_key_ctrl_off && pwdata[kc_verify_bit];

   backdoor_key_check #(.words(words), .width(width)) u_key (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(key_wr),
      .wr_idx(paddr[3:2]),
      .wr_data(pwdata[width-1:0]),
      .stored_key(nvm_key),
      .all_written(keys_written),
      .keys_valid(keys_valid),
      .keys_match(keys_match)
   );

   // only a reset clears the grant, since the copy is reloaded then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         backdoor_reg <= 1'b0; // R16
      end else if (verify_wr && in_run && normal_reg && backdoor_key_enable_bits == keyen_enabled &&
                   keys_written && keys_valid && keys_match) begin
         backdoor_reg <= 1'b1; // R09 R10
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_ctrl_reg <= '0;
      end else if (apb_wr && paddr == reg_key_ctrl_off) begin
         key_ctrl_reg[kc_access_bit] <= pwdata[kc_access_bit];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb register read path

   assign mapped = paddr == reg_copy_off || paddr == reg_status_off || paddr == reg_key_ctrl_off ||
                   paddr[7:4] == reg_key_base_off[7:4];
   always_comb begin
      status_w = '0;
      status_w[st_secured_bit] = secured;
      status_w[st_normal_bit] = normal_reg;
      status_w[st_dbg_en_bit] = dbg_enable;
      status_w[st_backdoor_bit] = backdoor_reg;
      status_w[st_active_dbg_bit] = active_dbg_reg;
      status_w[st_erase_unsec_bit] = erase_unsec_reg;
      status_w[st_ready_bit] = in_run;
   end

   // read data is latched in the setup cycle; key words read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (apb_setup) begin
         if (paddr == reg_copy_off) begin
            prdata_reg <= {24'h000000, flash_security_copy};
         end else if (paddr == reg_status_off) begin
            prdata_reg <= status_w;
         end else if (paddr == reg_key_ctrl_off) begin
            prdata_reg <= {30'h00000000, 1'b0, key_ctrl_reg[kc_access_bit]};
         end else begin
            prdata_reg <= '0;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence load_step_s;
      phase_reg == st_load;
   endsequence
   sequence run_next_s;
      ##1 phase_reg == st_run;
   endsequence

   copy_load_a: assert property (load_step_s |=> flash_security_copy == $past(nvm_opt_byte)) // R01
      else $error("security copy not loaded from options byte");
   sec_decode_a: assert property (in_run && security_state_bits != sec_unsecured && !backdoor_reg &&
                                  !erase_unsec_reg |-> secured) // R02
      else $error("device unsecured with a securing pattern");
   dbg_disable_a: assert property (secured && normal_reg |-> !dbg_enable && !dbg_cmd_accept) // R04
      else $error("debug active on secured normal device");
   cmd_restrict_a: assert property (secured && nvm_cmd_valid && nvm_cmd_code == cmd_program |-> !nvm_cmd_allow) // R05
      else $error("restricted nvm command allowed while secured");
   bdm_entry_a: assert property (phase_reg == st_load && !chip_mode_select_sync_reg |-> run_next_s ##0 active_debug_state) // R06
      else $error("active debug state not entered in special mode");
   dbg_filter_a: assert property (secured && !normal_reg && dbg_cmd_valid &&
                                  (dbg_cmd_class == dbg_mem || dbg_cmd_class == dbg_other) |-> dbg_cmd_reject) // R07
      else $error("secured debug accepted a forbidden command");
   mem_block_a: assert property (in_run && secured && !normal_reg |-> dbg_mem_block) // R08
      else $error("debug memory access open while secured");
   key_grant_a: assert property ($rose(backdoor_reg) |-> $past(keys_valid) && $past(normal_reg)) // R09 R10
      else $error("back door granted without a valid key");
   opt_protect_a: assert property (nvm_cmd_valid && opt_sector_hit && opt_sector_protected &&
                                   nvm_cmd_code == cmd_erase_sector |-> !nvm_cmd_allow) // R11
      else $error("protected options sector erase allowed");
   sector_align_a: assert property (nvm_cmd_allow && nvm_cmd_code == cmd_erase_sector |=>
                                    (nvm_erase_base & opt_sector_mask) == 24'h000000) // R12
      else $error("erase base not sector aligned");
   copy_hold_a: assert property (in_run |=> $stable(flash_security_copy)) // R13
      else $error("security copy changed outside reset");
   erase_unsec_a: assert property (nvm_erase_all_done && nvm_erase_all_ok && in_run |=>
                                   !secured && opt_prog_req && opt_prog_data == opt_byte_unsecured) // R14
      else $error("full erase did not unsecure");
   mode_capture_a: assert property (load_step_s |=> normal_run_chip_mode == $past(chip_mode_select_sync_reg)) // R15
      else $error("chip mode not captured at reset release");
   grant_hold_a: assert property (backdoor_reg |=> backdoor_reg) // R16
      else $error("back door grant dropped before reset");
endmodule : flash_security_control

// file: hw/flash_security_pkg.sv
// constants for the flash security control block
// assumes a 32-bit apb register window and 24-bit nonvolatile addresses
package flash_security_pkg;
   // register map, byte offsets
   localparam logic [7:0] reg_copy_off = 8'h00;
   localparam logic [7:0] reg_status_off = 8'h04;
   localparam logic [7:0] reg_key_ctrl_off = 8'h08;
   localparam logic [7:0] reg_key_base_off = 8'h10;
   localparam logic [7:0] reg_copy_rst = 8'hff;
   // options/security byte layout
   localparam int sec_lsb = 0;
   localparam int keyen_lsb = 6;
   localparam logic [1:0] sec_unsecured = 2'b10;
   localparam logic [1:0] sec_recommended = 2'b01;
   localparam logic [1:0] keyen_enabled = 2'b10;
   localparam logic [7:0] opt_byte_unsecured = 8'hfe;
   // status register bit positions
   localparam int st_secured_bit = 0;
   localparam int st_normal_bit = 1;
   localparam int st_dbg_en_bit = 2;
   localparam int st_backdoor_bit = 3;
   localparam int st_active_dbg_bit = 4;
   localparam int st_erase_unsec_bit = 5;
   localparam int st_ready_bit = 6;
   // key control bit positions
   localparam int kc_access_bit = 0;
   localparam int kc_verify_bit = 1;
   // back door key store
   localparam int key_words = 4;
   localparam int key_width = 16;
   localparam logic [15:0] key_invalid_lo = 16'h0000;
   localparam logic [15:0] key_invalid_hi = 16'hffff;
   // nonvolatile command codes
   localparam logic [7:0] cmd_erase_verify_all = 8'h01;
   localparam logic [7:0] cmd_program = 8'h06;
   localparam logic [7:0] cmd_erase_all = 8'h08;
   localparam logic [7:0] cmd_erase_sector = 8'h0a;
   // sector that holds the options/security byte
   localparam logic [23:0] opt_sector_base = 24'h7ffe00;
   localparam logic [23:0] opt_sector_mask = 24'h0001ff;
   localparam logic [23:0] opt_sector_last = 24'h7fffff;
   // mode pin synchroniser depth, cycles before capture
   localparam logic [1:0] sync_wait = 2'h2;
   typedef enum logic [1:0] {dbg_mass_erase, dbg_csr, dbg_mem, dbg_other} dbg_class_e;
endpackage : flash_security_pkg
